/* File: inc/cps_cfg.svh */
// Purpose: Constants of the processor state and flags block
// Assumes: 200 MHz system clock
// Notes:   Offsets are for the plain register port
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH
`define CPS_SP_RST        16'h00ff
`define CPS_SP_LOW_PRESET 8'hff
`define CPS_RST_VEC       16'hfffe
`define CPS_IRQ_VEC_TOP   16'hfffc
`define CPS_IRQ_N         4
`define CPS_F_V           7
`define CPS_F_H           4
`define CPS_F_I           3
`define CPS_F_N           2
`define CPS_F_Z           1
`define CPS_F_C           0
`define CPS_F_ONES        8'h60
`define CPS_FLAGS_RST     8'h68
`define CPS_CLK_NS        5
`define CPS_STAB_NS       20480
`define CPS_STAB_CYC      ((`CPS_STAB_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_PUSH_LAST     3'h4
`define CPS_TAG_FLAGS     3'h0
`define CPS_TAG_ACC       3'h1
`define CPS_TAG_IDX_LO    3'h2
`define CPS_TAG_PC_HI     3'h3
`define CPS_TAG_PC_LO     3'h4
`define CPS_TAG_IDX_HI    3'h5
`define CPS_REG_ACC       4'h0
`define CPS_REG_IDX_HI    4'h1
`define CPS_REG_IDX_LO    4'h2
`define CPS_REG_SP_HI     4'h3
`define CPS_REG_SP_LO     4'h4
`define CPS_REG_PC_HI     4'h5
`define CPS_REG_PC_LO     4'h6
`define CPS_REG_FLAGS     4'h7
`define CPS_REG_STATUS    4'h8
`define CPS_REG_IRQ_EN    4'h9
`endif

/* File: inc/cps_pkg.sv */
// Purpose: Types of the processor state and flags block
// Assumes: Nothing
// Notes:   Operation codes come from the instruction decoder
package cps_pkg;
  typedef enum logic [4:0] {
    OP_NOP   = 5'h00,
    OP_ADD   = 5'h01,
    OP_ADC   = 5'h02,
    OP_SUB   = 5'h03,
    OP_AND   = 5'h04,
    OP_LDA   = 5'h05,
    OP_ASL   = 5'h06,
    OP_ROR   = 5'h07,
    OP_BTST  = 5'h08,
    OP_LDX   = 5'h09,
    OP_LDH   = 5'h0a,
    OP_LDHX  = 5'h0b,
    OP_RSP   = 5'h0c,
    OP_PUSH_INDEX_HIGH_OP  = 5'h0d,
    OP_PULL_INDEX_HIGH_OP  = 5'h0e,
    OP_JMP   = 5'h0f,
    OP_FETCH = 5'h10,
    OP_CLI   = 5'h11,
    OP_SEI   = 5'h12,
    OP_RTI   = 5'h13,
    OP_WAIT  = 5'h14,
    OP_STOP  = 5'h15
  } cps_op_e;

  typedef enum logic [3:0] {
    S_RUN  = 4'h0,
    S_VEC  = 4'h1,
    S_PUSH = 4'h2,
    S_RTI  = 4'h3,
    S_PULL_INDEX_HIGH_OP = 4'h4,
    S_WAIT = 4'h5,
    S_STOP = 4'h6,
    S_STAB = 4'h7
  } cps_state_e;
endpackage

/* File: hw/cps_alu.sv */
// Purpose: Result and flag logic for one working byte operation
// Assumes: Purely combinational, used by cps_core
// Notes:   Tells the core which flags and whether the working byte update
`timescale 1ns/1ps
module cps_alu #(
  parameter int unsigned W = 8
)(
  input  wire cps_pkg::cps_op_e op_i,
  input  wire logic [W-1:0]     a_i,
  input  wire logic [W-1:0]     b_i,
  input  wire logic             cin_i,
  output logic      [W-1:0]     res_o,
  output logic                  v_o,
  output logic                  h_o,
  output logic                  c_o,
  output logic                  n_o,
  output logic                  z_o,
  output logic                  wr_acc_o,
  output logic                  upd_vnz_o,
  output logic                  upd_h_o,
  output logic                  upd_c_o
);
  logic [W:0] sum;
  logic       ci;

  always_comb begin
    sum       = '0;
    ci        = 1'b0;
    res_o     = a_i;
    v_o       = 1'b0;
    h_o       = 1'b0;
    c_o       = 1'b0;
    wr_acc_o  = 1'b0;
    upd_vnz_o = 1'b0;
    upd_h_o   = 1'b0;
    upd_c_o   = 1'b0;
    case (op_i)
      cps_pkg::OP_ADD, cps_pkg::OP_ADC: begin
        ci        = (op_i == cps_pkg::OP_ADC) ? cin_i : 1'b0;
        sum       = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, ci};
        res_o     = sum[W-1:0];
        c_o       = sum[W];
        v_o       = (a_i[W-1] == b_i[W-1]) && (res_o[W-1] != a_i[W-1]);
        h_o       = a_i[4] ^ b_i[4] ^ res_o[4];
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
        upd_h_o   = 1'b1;
        upd_c_o   = 1'b1;
      end
      cps_pkg::OP_SUB: begin
        sum       = {1'b0, a_i} - {1'b0, b_i};
        res_o     = sum[W-1:0];
        c_o       = sum[W];
        v_o       = (a_i[W-1] != b_i[W-1]) && (res_o[W-1] != a_i[W-1]);
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
        upd_c_o   = 1'b1;
      end
      cps_pkg::OP_AND: begin
        res_o     = a_i & b_i;
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
      end
      cps_pkg::OP_LDA: begin
        res_o     = b_i;
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
      end
      cps_pkg::OP_ASL: begin
        res_o     = {a_i[W-2:0], 1'b0};
        c_o       = a_i[W-1];
        v_o       = res_o[W-1] ^ c_o;
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
        upd_c_o   = 1'b1;
      end
      cps_pkg::OP_ROR: begin
        res_o     = {cin_i, a_i[W-1:1]};
        c_o       = a_i[0];
        v_o       = res_o[W-1] ^ c_o;
        wr_acc_o  = 1'b1;
        upd_vnz_o = 1'b1;
        upd_c_o   = 1'b1;
      end
      cps_pkg::OP_BTST: begin
        c_o       = a_i[b_i[$clog2(W)-1:0]];
        upd_c_o   = 1'b1;
      end
      default: begin
        res_o     = a_i;
      end
    endcase
    n_o = res_o[W-1];
    z_o = (res_o == '0);
  end
endmodule

/* File: hw/cps_core.sv */
// Purpose: Programmer-visible state and condition flags of an 8-bit core
// Assumes: Decoder supplies one operation per cycle, memory answers reads next cycle
// Notes:   Interrupt entry and return move bytes over the memory port
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cps_cfg.svh"
module cps_core #(
  parameter int unsigned IRQ_N    = `CPS_IRQ_N,
  parameter int unsigned STAB_CYC = `CPS_STAB_CYC
)(
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_B_I,
  input  wire logic             OP_VALID_I,
  input  wire cps_pkg::cps_op_e OP_CODE_I,
  input  wire logic [15:0]      OP_DATA_I,
  input  wire logic [IRQ_N-1:0] IRQ_REQ_I,
  input  wire logic [7:0]       MEM_RDATA_I,
  input  wire logic [3:0]       REG_ADDR_I,
  input  wire logic [7:0]       REG_WDATA_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  output logic                  OP_READY_O,
  output logic                  CPU_CLK_EN_O,
  output logic [7:0]            FLAGS_O,
  output logic [15:0]           MEM_ADDR_O,
  output logic [7:0]            MEM_WDATA_O,
  output logic                  MEM_WR_O,
  output logic                  MEM_RD_O,
  output logic [7:0]            REG_RDATA_O
);
  localparam int unsigned SRCW = (IRQ_N > 1) ? $clog2(IRQ_N) : 1;
  localparam int unsigned CNTW = $clog2(STAB_CYC + 1);

  cps_pkg::cps_state_e state;
  cps_pkg::cps_state_e next_state;
  logic [7:0]          acc;
  logic [7:0]          idx_hi;
  logic [7:0]          idx_lo;
  logic [7:0]          flags;
  logic [15:0]         sp;
  logic [15:0]         pc;
  logic [15:0]         vec_addr;
  logic [2:0]          step;
  logic [2:0]          tag_a;
  logic [2:0]          tag_b;
  logic                rd_q;
  logic                up_q;
  logic [IRQ_N-1:0]    irq_en;
  logic [CNTW-1:0]     stab_cnt;
  logic [IRQ_N-1:0]    pend;
  logic [SRCW-1:0]     src;
  logic                take_irq;
  logic                accept;
  logic                cap;
  logic [2:0]          last_tag;
  logic                iss_rd;
  logic                iss_wr;
  logic [15:0]         iss_addr;
  logic [7:0]          iss_data;
  logic [2:0]          iss_tag;
  logic [7:0]          alu_res;
  logic                alu_v;
  logic                alu_h;
  logic                alu_c;
  logic                alu_n;
  logic                alu_z;
  logic                alu_wr;
  logic                alu_vnz;
  logic                alu_uh;
  logic                alu_uc;

  cps_alu #(
    .W (8)
  ) u_alu (
    .op_i      (OP_CODE_I),
    .a_i       (acc),
    .b_i       (OP_DATA_I[7:0]),
    .cin_i     (flags[`CPS_F_C]),
    .res_o     (alu_res),
    .v_o       (alu_v),
    .h_o       (alu_h),
    .c_o       (alu_c),
    .n_o       (alu_n),
    .z_o       (alu_z),
    .wr_acc_o  (alu_wr),
    .upd_vnz_o (alu_vnz),
    .upd_h_o   (alu_uh),
    .upd_c_o   (alu_uc)
  );

  assign pend     = IRQ_REQ_I & irq_en;
  assign take_irq = (state == cps_pkg::S_RUN) && !flags[`CPS_F_I] && (|pend);
  // An interrupt at an operation boundary wins; the decoder holds the operation
  assign accept   = OP_VALID_I && OP_READY_O && (state == cps_pkg::S_RUN) && !take_irq;
  assign cap      = rd_q;
  assign last_tag = (state == cps_pkg::S_PULL_INDEX_HIGH_OP) ? `CPS_TAG_IDX_HI : `CPS_TAG_PC_LO;
  assign FLAGS_O  = flags;

  // Lowest index is highest priority
  always_comb begin
    src = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        src = SRCW'(i);
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      cps_pkg::S_RUN: begin
        if (take_irq) begin
          next_state = cps_pkg::S_PUSH;
        end else if (accept) begin
          if (OP_CODE_I == cps_pkg::OP_RTI) begin
            next_state = cps_pkg::S_RTI;
          end else if (OP_CODE_I == cps_pkg::OP_PULL_INDEX_HIGH_OP) begin
            next_state = cps_pkg::S_PULL_INDEX_HIGH_OP;
          end else if (OP_CODE_I == cps_pkg::OP_WAIT) begin
            next_state = cps_pkg::S_WAIT;
          end else if (OP_CODE_I == cps_pkg::OP_STOP) begin
            next_state = cps_pkg::S_STOP;
          end
        end
      end
      cps_pkg::S_PUSH: begin
        if (step == `CPS_PUSH_LAST) begin
          next_state = cps_pkg::S_VEC;
        end
      end
      cps_pkg::S_VEC, cps_pkg::S_RTI, cps_pkg::S_PULL_INDEX_HIGH_OP: begin
        if (cap && (tag_b == last_tag)) begin
          next_state = cps_pkg::S_RUN;
        end
      end
      cps_pkg::S_WAIT: begin
        if (|pend) begin
          next_state = cps_pkg::S_RUN;
        end
      end
      cps_pkg::S_STOP: begin
        if (pend[0]) begin
          next_state = cps_pkg::S_STAB;
        end
      end
      cps_pkg::S_STAB: begin
        if (stab_cnt == CNTW'(1)) begin
          next_state = cps_pkg::S_RUN;
        end
      end
      default: begin
        next_state = cps_pkg::S_RUN;
      end
    endcase
  end

  // Bus requests of each sequence; stacking order is fetch low, fetch high, index low,
  // working byte, flags, and the index upper byte is left out for compatibility
  always_comb begin
    iss_rd   = 1'b0;
    iss_wr   = 1'b0;
    iss_addr = sp;
    iss_data = 8'h00;
    iss_tag  = step;
    case (state)
      cps_pkg::S_PUSH: begin
        iss_wr = 1'b1;
        case (step)
          3'h0:    iss_data = pc[7:0];
          3'h1:    iss_data = pc[15:8];
          3'h2:    iss_data = idx_lo;
          3'h3:    iss_data = acc;
          default: iss_data = flags;
        endcase
      end
      cps_pkg::S_VEC: begin
        iss_rd   = (step < 3'h2);
        iss_addr = vec_addr + {15'h0000, step[0]};
        iss_tag  = `CPS_TAG_PC_HI + step;
      end
      cps_pkg::S_RTI: begin
        iss_rd   = (step <= `CPS_PUSH_LAST);
        iss_addr = sp + 16'h0001;
      end
      cps_pkg::S_PULL_INDEX_HIGH_OP: begin
        iss_rd   = (step == 3'h0);
        iss_addr = sp + 16'h0001;
        iss_tag  = `CPS_TAG_IDX_HI;
      end
      cps_pkg::S_RUN: begin
        iss_wr   = accept && (OP_CODE_I == cps_pkg::OP_PUSH_INDEX_HIGH_OP);
        iss_data = idx_hi;
      end
      default: begin
        iss_wr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MEM_RD_O    <= 1'b0;
      MEM_WR_O    <= 1'b0;
      MEM_ADDR_O  <= 16'h0000;
      MEM_WDATA_O <= 8'h00;
      tag_a       <= 3'h0;
      tag_b       <= 3'h0;
      rd_q        <= 1'b0;
    end else begin
      MEM_RD_O    <= iss_rd;
      MEM_WR_O    <= iss_wr;
      MEM_ADDR_O  <= iss_addr;
      MEM_WDATA_O <= iss_data;
      tag_a       <= iss_tag;
      tag_b       <= tag_a;
      rd_q        <= MEM_RD_O;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state    <= cps_pkg::S_VEC;
      step     <= 3'h0;
      stab_cnt <= '0;
      vec_addr <= `CPS_RST_VEC;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        step <= 3'h0;
      end else if (iss_rd || iss_wr) begin
        step <= step + 3'h1;
      end
      if (take_irq) begin
        vec_addr <= `CPS_IRQ_VEC_TOP - 16'({src, 1'b0});
      end
      if (next_state == cps_pkg::S_STAB && state != cps_pkg::S_STAB) begin
        stab_cnt <= CNTW'(STAB_CYC);
      end else if (state == cps_pkg::S_STAB) begin
        stab_cnt <= stab_cnt - CNTW'(1);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sp <= `CPS_SP_RST;
    end else if (accept && OP_CODE_I == cps_pkg::OP_RSP) begin
      sp[7:0] <= `CPS_SP_LOW_PRESET;
    end else if (iss_wr) begin
      sp <= sp - 16'h0001;
    end else if (iss_rd && state != cps_pkg::S_VEC) begin
      sp <= sp + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pc <= 16'h0000;
    end else if (cap && tag_b == `CPS_TAG_PC_HI) begin
      pc[15:8] <= MEM_RDATA_I;
    end else if (cap && tag_b == `CPS_TAG_PC_LO) begin
      pc[7:0] <= MEM_RDATA_I;
    end else if (accept && OP_CODE_I == cps_pkg::OP_FETCH) begin
      pc <= pc + 16'h0001;
    end else if (accept && OP_CODE_I == cps_pkg::OP_JMP) begin
      pc <= OP_DATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc <= 8'h00;
    end else if (cap && tag_b == `CPS_TAG_ACC) begin
      acc <= MEM_RDATA_I;
    end else if (accept && alu_wr) begin
      acc <= alu_res;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      idx_hi <= 8'h00;
      idx_lo <= 8'h00;
    end else begin
      if (cap && tag_b == `CPS_TAG_IDX_HI) begin
        idx_hi <= MEM_RDATA_I;
      end else if (accept && (OP_CODE_I == cps_pkg::OP_LDH)) begin
        idx_hi <= OP_DATA_I[7:0];
      end else if (accept && (OP_CODE_I == cps_pkg::OP_LDHX)) begin
        idx_hi <= OP_DATA_I[15:8];
      end
      if (cap && tag_b == `CPS_TAG_IDX_LO) begin
        idx_lo <= MEM_RDATA_I;
      end else if (accept && (OP_CODE_I == cps_pkg::OP_LDX ||
                              OP_CODE_I == cps_pkg::OP_LDHX)) begin
        idx_lo <= OP_DATA_I[7:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flags <= `CPS_FLAGS_RST;
    end else if (state == cps_pkg::S_RTI && cap && tag_b == `CPS_TAG_FLAGS) begin
      flags <= MEM_RDATA_I | `CPS_F_ONES;
    end else if (state == cps_pkg::S_PUSH && step == `CPS_PUSH_LAST) begin
      flags[`CPS_F_I] <= 1'b1;
    end else if (accept) begin
      case (OP_CODE_I)
        cps_pkg::OP_CLI:  flags[`CPS_F_I] <= 1'b0;
        cps_pkg::OP_SEI:  flags[`CPS_F_I] <= 1'b1;
        cps_pkg::OP_WAIT: flags[`CPS_F_I] <= 1'b0;
        cps_pkg::OP_STOP: flags[`CPS_F_I] <= 1'b0;
        default: begin
          if (alu_vnz) begin
            flags[`CPS_F_V] <= alu_v;
            flags[`CPS_F_N] <= alu_n;
            flags[`CPS_F_Z] <= alu_z;
          end
          if (alu_uh) begin
            flags[`CPS_F_H] <= alu_h;
          end
          if (alu_uc) begin
            flags[`CPS_F_C] <= alu_c;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OP_READY_O   <= 1'b0;
      CPU_CLK_EN_O <= 1'b1;
      up_q         <= 1'b0;
    end else begin
      OP_READY_O   <= (next_state == cps_pkg::S_RUN) && !take_irq;
      CPU_CLK_EN_O <= !(next_state == cps_pkg::S_WAIT || next_state == cps_pkg::S_STOP ||
                        next_state == cps_pkg::S_STAB);
      up_q         <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_en <= '1;
    end else if (REG_WR_I && REG_ADDR_I == `CPS_REG_IRQ_EN) begin
      irq_en <= REG_WDATA_I[IRQ_N-1:0];
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (!REG_RD_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_ADDR_I == `CPS_REG_ACC) begin
      REG_RDATA_O <= acc;
    end else if (REG_ADDR_I == `CPS_REG_IDX_HI) begin
      REG_RDATA_O <= idx_hi;
    end else if (REG_ADDR_I == `CPS_REG_IDX_LO) begin
      REG_RDATA_O <= idx_lo;
    end else if (REG_ADDR_I == `CPS_REG_SP_HI) begin
      REG_RDATA_O <= sp[15:8];
    end else if (REG_ADDR_I == `CPS_REG_SP_LO) begin
      REG_RDATA_O <= sp[7:0];
    end else if (REG_ADDR_I == `CPS_REG_PC_HI) begin
      REG_RDATA_O <= pc[15:8];
    end else if (REG_ADDR_I == `CPS_REG_PC_LO) begin
      REG_RDATA_O <= pc[7:0];
    end else if (REG_ADDR_I == `CPS_REG_FLAGS) begin
      REG_RDATA_O <= flags | `CPS_F_ONES;
    end else if (REG_ADDR_I == `CPS_REG_STATUS) begin
      REG_RDATA_O <= {4'h0, state};
    end else if (REG_ADDR_I == `CPS_REG_IRQ_EN) begin
      REG_RDATA_O <= 8'(irq_en);
    end else begin
      REG_RDATA_O <= 8'h00;
    end
  end

  AST_SP_RESET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $rose(up_q) |-> sp == `CPS_SP_RST)
    else $error("stack top pointer not 00ff after reset");
  AST_SP_PRESET: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    accept && OP_CODE_I == cps_pkg::OP_RSP |=>
      sp[7:0] == 8'hff && sp[15:8] == $past(sp[15:8]))
    else $error("stack low byte preset wrong");
  AST_SP_PUSH: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    state == cps_pkg::S_PUSH |=> sp == $past(sp) - 16'h0001)
    else $error("stack pointer did not step down on push");
  AST_FETCH: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    accept && OP_CODE_I == cps_pkg::OP_FETCH |=> pc == $past(pc) + 16'h0001)
    else $error("fetch pointer did not advance");
  AST_ONES: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    FLAGS_O[6:5] == 2'b11)
    else $error("flags bits 6 and 5 not one");
  AST_HALF: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    accept && OP_CODE_I == cps_pkg::OP_ADD |=>
      flags[4] == (({1'b0, $past(acc[3:0])} + {1'b0, $past(OP_DATA_I[3:0])}) > 5'h0f))
    else $error("nibble carry wrong after add");
  AST_MASK: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    flags[3] && state == cps_pkg::S_RUN |=> state != cps_pkg::S_PUSH)
    else $error("interrupt taken while masked");
  AST_ENTRY: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    take_irq |=> !flags[3] [*5] ##1 flags[3] && state == cps_pkg::S_VEC && !MEM_RD_O)
    else $error("mask not set between stacking and vector fetch");
  AST_ZERO: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    accept && OP_CODE_I == cps_pkg::OP_AND |=>
      flags[1] == (($past(acc) & $past(OP_DATA_I[7:0])) == 8'h00))
    else $error("zero flag wrong after and");
  AST_WAIT: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    accept && OP_CODE_I == cps_pkg::OP_WAIT |=> !flags[3] && !CPU_CLK_EN_O)
    else $error("wait did not clear mask and stop clock");
  AST_STAB: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I)
    state == cps_pkg::S_STAB |-> !CPU_CLK_EN_O)
    else $error("clock running during stabilization");
endmodule

/* File: test/cps_mem_model.sv */
// Purpose: Memory partner of the state and flags block
// Assumes: Reads answered the next cycle, writes stored at once
// Notes:   Idle read data toggles so a stale byte never looks valid
`timescale 1ns/1ps
module cps_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];
  initial begin
    rdata_o = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    for (int i = 0; i < 4; i++) begin
      mem[16'hfffc - 2 * i] = 8'h40;
      mem[16'hfffd - 2 * i] = 8'(i);
    end
    mem[16'hfffe] = 8'h12;
    mem[16'hffff] = 8'h34;
  end
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
  end
endmodule

/* File: test/test_cps_core.sv */
// Purpose: Self-checking bench of the state and flags block
// Assumes: Memory partner answers each read one cycle later
// Notes:   Short stabilisation count keeps stop tests brief
`timescale 1ns/1ps
`include "cps_cfg.svh"
module test_cps_core;
  logic             CLK_SYS_I, RST_B_I, OP_VALID_I, REG_WR_I, REG_RD_I;
  logic             OP_READY_O, CPU_CLK_EN_O, MEM_WR_O, MEM_RD_O;
  cps_pkg::cps_op_e OP_CODE_I;
  logic [15:0]      OP_DATA_I, MEM_ADDR_O;
  logic [3:0]       IRQ_REQ_I, REG_ADDR_I;
  logic [7:0]       MEM_RDATA_I, REG_WDATA_I, FLAGS_O, MEM_WDATA_O, REG_RDATA_O;
  int               num_errors = 0, n_tests = 0, cyc = 0, n;
  cps_pkg::cps_op_e t_op [11] = '{cps_pkg::OP_LDA, cps_pkg::OP_ADD, cps_pkg::OP_LDA,
    cps_pkg::OP_ADD, cps_pkg::OP_SUB, cps_pkg::OP_AND, cps_pkg::OP_LDA, cps_pkg::OP_ASL,
    cps_pkg::OP_ROR, cps_pkg::OP_BTST, cps_pkg::OP_ADC};
  // Operand, flags, working byte
  logic [23:0]      t_ex [11] = '{24'h8f6c8f, 24'h717b00, 24'h7f797f, 24'h01fc80, 24'h01f87f,
    24'h007a00, 24'h817c81, 24'h00f902, 24'h00fc81, 24'h00fd81, 24'h0e7c90};
  cps_core #(.STAB_CYC(4)) dut_u (.CLK_SYS_I, .RST_B_I, .OP_VALID_I, .OP_CODE_I, .OP_DATA_I,
    .IRQ_REQ_I, .MEM_RDATA_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .OP_READY_O,
    .CPU_CLK_EN_O, .FLAGS_O, .MEM_ADDR_O, .MEM_WDATA_O, .MEM_WR_O, .MEM_RD_O, .REG_RDATA_O);
  cps_mem_model mem_u (.clk_i(CLK_SYS_I), .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O),
    .wr_i(MEM_WR_O), .rd_i(MEM_RD_O), .rdata_o(MEM_RDATA_I));
  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge CLK_SYS_I);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= w;
    @(posedge CLK_SYS_I);
    REG_WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK_SYS_I);
    REG_RD_I <= 1'b1;
    REG_ADDR_I <= a;
    @(posedge CLK_SYS_I);
    REG_RD_I <= 1'b0;
    @(posedge CLK_SYS_I);
    chk($sformatf("reg %h", a), e, REG_RDATA_O);
  endtask
  // Held until sampled ready; results are read two edges later
  task automatic op(input cps_pkg::cps_op_e c, input logic [15:0] x);
    @(posedge CLK_SYS_I);
    OP_VALID_I <= 1'b1;
    OP_CODE_I <= c;
    OP_DATA_I <= x;
    do @(posedge CLK_SYS_I); while (OP_READY_O !== 1'b1 && cyc < 20000);
    OP_VALID_I <= 1'b0;
    repeat (2) @(posedge CLK_SYS_I);
  endtask
  task automatic wready(input bit lo);
    for (int i = 0; i < 50 && lo && OP_READY_O !== 1'b0; i++) @(posedge CLK_SYS_I);
    for (int i = 0; i < 50 && OP_READY_O !== 1'b1; i++) @(posedge CLK_SYS_I);
  endtask
  task automatic chkrst();
    wready(1'b0);
    chk("flags", 8'h68, FLAGS_O);
    rd(`CPS_REG_SP_HI, 8'h00);
    rd(`CPS_REG_SP_LO, 8'hff);
    rd(`CPS_REG_PC_HI, 8'h12);
    rd(`CPS_REG_PC_LO, 8'h34);
  endtask
  always #2.5 CLK_SYS_I = ~CLK_SYS_I;
  always @(posedge CLK_SYS_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    CLK_SYS_I = 1'b0;
    RST_B_I = 1'b0;
    OP_VALID_I = 1'b0;
    OP_CODE_I = cps_pkg::OP_NOP;
    OP_DATA_I = 16'h0000;
    IRQ_REQ_I = 4'h0;
    REG_ADDR_I = 4'h0;
    REG_WDATA_I = 8'h00;
    REG_WR_I = 1'b0;
    REG_RD_I = 1'b0;
    repeat (3) @(posedge CLK_SYS_I);
    RST_B_I <= 1'b1;
    chkrst();
    wr(4'hf, 8'h55);
    rd(4'hf, 8'h00);
    foreach (t_op[i]) begin
      op(t_op[i], {8'h00, t_ex[i][23:16]});
      chk("flags", t_ex[i][15:8], FLAGS_O);
      rd(`CPS_REG_ACC, t_ex[i][7:0]);
    end
    op(cps_pkg::OP_LDHX, 16'h5a3c);
    rd(`CPS_REG_IDX_HI, 8'h5a);
    rd(`CPS_REG_IDX_LO, 8'h3c);
    op(cps_pkg::OP_PUSH_INDEX_HIGH_OP, 16'h0000);
    rd(`CPS_REG_SP_LO, 8'hfe);
    chk("stack", 8'h5a, mem_u.mem[16'h00ff]);
    op(cps_pkg::OP_LDH, 16'h00a5);
    op(cps_pkg::OP_LDX, 16'h0096);
    rd(`CPS_REG_IDX_HI, 8'ha5);
    rd(`CPS_REG_IDX_LO, 8'h96);
    op(cps_pkg::OP_PULL_INDEX_HIGH_OP, 16'h0000);
    wready(1'b1);
    rd(`CPS_REG_SP_LO, 8'hff);
    rd(`CPS_REG_IDX_HI, 8'h5a);
    op(cps_pkg::OP_PUSH_INDEX_HIGH_OP, 16'h0000);
    op(cps_pkg::OP_RSP, 16'h0000);
    rd(`CPS_REG_SP_LO, 8'hff);
    rd(`CPS_REG_SP_HI, 8'h00);
    op(cps_pkg::OP_JMP, 16'h4567);
    op(cps_pkg::OP_FETCH, 16'h0000);
    IRQ_REQ_I <= 4'h6;
    op(cps_pkg::OP_NOP, 16'h0000);
    rd(`CPS_REG_PC_LO, 8'h68);
    op(cps_pkg::OP_CLI, 16'h0000);
    wready(1'b1);
    rd(`CPS_REG_PC_LO, 8'h01);
    chk("mask", 8'h08, FLAGS_O & 8'h08);
    chk("stacked", 8'h60, mem_u.mem[16'h00fb] & 8'h68);
    rd(`CPS_REG_SP_LO, 8'hfa);
    IRQ_REQ_I <= 4'h0;
    op(cps_pkg::OP_RTI, 16'h0000);
    wready(1'b1);
    chk("mask", 8'h00, FLAGS_O & 8'h08);
    rd(`CPS_REG_PC_LO, 8'h68);
    wr(`CPS_REG_IRQ_EN, 8'h08);
    rd(`CPS_REG_IRQ_EN, 8'h08);
    op(cps_pkg::OP_SEI, 16'h0000);
    chk("mask", 8'h08, FLAGS_O & 8'h08);
    // Poisoned so that only the wake-up stacking can clear it
    mem_u.mem[16'h00fb] = 8'hff;
    op(cps_pkg::OP_WAIT, 16'h0000);
    chk("clk", 8'h00, {7'h0, CPU_CLK_EN_O});
    chk("mask", 8'h00, FLAGS_O & 8'h08);
    rd(`CPS_REG_STATUS, {4'h0, cps_pkg::S_WAIT});
    IRQ_REQ_I <= 4'h8;
    // Ready shows for one cycle on wake before the pending request wins
    wready(1'b0);
    wready(1'b1);
    rd(`CPS_REG_PC_LO, 8'h03);
    chk("stacked", 8'h60, mem_u.mem[16'h00fb] & 8'h68);
    IRQ_REQ_I <= 4'h0;
    wr(`CPS_REG_IRQ_EN, 8'h0f);
    op(cps_pkg::OP_STOP, 16'h0000);
    IRQ_REQ_I <= 4'h2;
    repeat (8) @(posedge CLK_SYS_I);
    chk("clk", 8'h00, {7'h0, CPU_CLK_EN_O});
    IRQ_REQ_I <= 4'h1;
    for (n = 0; n < 50 && CPU_CLK_EN_O !== 1'b1; n++) @(posedge CLK_SYS_I);
    chk("stab", 8'h01, {7'h0, n >= 4 && n < 50});
    wready(1'b1);
    rd(`CPS_REG_PC_LO, 8'h00);
    chk("stacked", 8'h60, mem_u.mem[16'h00f6] & 8'h68);
    IRQ_REQ_I <= 4'h0;
    op(cps_pkg::OP_STOP, 16'h0000);
    RST_B_I <= 1'b0;
    repeat (3) @(posedge CLK_SYS_I);
    RST_B_I <= 1'b1;
    chkrst();
    wrap_up();
  end
endmodule
